// >>> bench/gas_sensor_compensation_measure_cmds_tb.sv
/*
  Self-checking bench of the gas sensor command handler.
  Assumes the Wishbone slave acks within a few cycles and meas_cycles 20.
*/
`timescale 1ns/1ps
module gas_sensor_compensation_measure_cmds_tb
  import gas_cmd_pkg::*;
;
  localparam int unsigned MC = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  link_in_t link_in;
  link_out_t link_out;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic a;
  logic [31:0] r;
  logic [15:0] v;
  logic [15:0] cd;
  logic [7:0] d8;

`define CMP(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end

  gas_cmd_core #(.meas_cycles(MC)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_in(link_in), .link_out(link_out));
  i2c_host_model host_u (.ref_clk(ref_clk), .link_out(link_out), .link_in(link_in));

  always #2 ref_clk = ~ref_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= ad;
    wb_wdat <= d;
    wb_sel <= 4'hF;
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic chk(input logic [7:0] ad, input logic [31:0] e, input string what);
    wb(1'b0, ad, 32'h0000_0000, r);
    `CMP(what, e, r)
  endtask : chk

  task automatic start_meas();
    host_u.send(CMD_MEAS, 16'h0000, 0, 0, a);
    host_u.pulse(1, 8'h00);
    host_u.get_ack(a);
    `CMP("early header", 1'b0, a)
    repeat (MC + 4) @(posedge ref_clk);
  endtask : start_meas

  task automatic read_out(input logic [15:0] c, input logic [15:0] t, input int n);
    logic [7:0] e [9];
    logic [7:0] d;
    e = '{c[15:8], c[7:0], host_u.sum8(c), t[15:8], t[7:0], host_u.sum8(t),
          8'h00, 8'h00, host_u.sum8(16'h0000)};
    host_u.pulse(1, 8'h00);
    host_u.get_ack(a);
    `CMP("ready header", 1'b1, a)
    for (int i = 0; i < n; i++) begin
      host_u.rd_byte(d);
      `CMP("read byte", e[i], d)
    end
    host_u.pulse(3, 8'h00);
  endtask : read_out

  task automatic recal(input logic [15:0] rv, input int na, input int ck,
                       input logic ea, input logic [15:0] ofs);
    host_u.send(CMD_RECAL, rv, na, ck, a);
    `CMP("recal ack", ea, a)
    wb(1'b0, ADR_STATUS, 32'h0000_0000, r);
    `CMP("recal busy", 1'b1, r[1])
    repeat (MC + 4) @(posedge ref_clk);
    wb(1'b0, ADR_STATUS, 32'h0000_0000, r);
    `CMP("recal done", 2'b10, {r[4], r[2]})
    wb(1'b0, ADR_TEMP_OFS, 32'h0000_0000, r);
    `CMP("offset", ofs, r[31:16])
  endtask : recal

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk(ADR_STATUS, 32'h0000_0001, "status");
    chk(ADR_HUM_PRES, {PRES_DEFAULT, HUM_DEFAULT}, "defaults");
    chk(8'h20, 32'h0000_0000, "unmapped");
    wb(1'b1, ADR_CTRL, 32'h0000_0001, r);
    wb(1'b1, ADR_RAW, 32'h1A2B_0123, r);
    chk(ADR_RAW, 32'h1A2B_0123, "raw");
    host_u.send(CMD_PRES, 16'h03E8, 2, 1, a);
    start_meas();
    read_out(16'h0123, 16'h1A2B, 2);
    read_out(16'h0123, 16'h1A2B, 9);
    for (int i = 0; i < 3; i++) begin
      cd = (i == 0) ? CMD_HUM : ((i == 1) ? CMD_PRES : CMD_TEMP);
      v = 16'h8001 + 16'(i);
      host_u.send(cd, v, 2, 1, a);
      `CMP("good ack", 1'b1, a)
      host_u.send(cd, 16'h5555, 2, 2, a);
      `CMP("bad ack", 1'b0, a)
      wb(1'b0, (i == 2) ? ADR_TEMP_OFS : ADR_HUM_PRES, 32'h0000_0000, r);
      `CMP("kept", v, (i == 1) ? r[31:16] : r[15:0])
    end
    start_meas();
    read_out(16'h0123, 16'h8003, 6);
    recal(16'h0400, 2, 1, 1'b1, 16'h02DD);
    start_meas();
    read_out(16'h0400, 16'h8003, 3);
    recal(16'h0400, 2, 2, 1'b0, 16'hFEDD);
    wb(1'b1, ADR_RAW, 32'h1A2B_0050, r);
    recal(16'h0000, 0, 0, 1'b1, 16'hFFB0);
    wb(1'b1, ADR_CTRL, 32'h0000_0011, r);
    start_meas();
    read_out(16'h0050, 16'h8003, 3);
    wb(1'b1, ADR_CTRL, 32'h0000_0000, r);
    start_meas();
    host_u.pulse(1, 8'h00);
    host_u.get_ack(a);
    `CMP("no gas header", 1'b0, a)
    host_u.send(CMD_CRC_OFF, 16'h0000, 0, 0, a);
    chk(ADR_STATUS, 32'h0000_001C, "crc off");
    host_u.send(CMD_PRES, 16'h0258, 2, 0, a);
    `CMP("plain ack", 1'b1, a)
    chk(ADR_HUM_PRES, 32'h0258_8001, "plain pres");
    wb(1'b1, ADR_CTRL, 32'h0000_0001, r);
    start_meas();
    host_u.pulse(1, 8'h00);
    host_u.get_ack(a);
    `CMP("plain header", 1'b1, a)
    for (int i = 0; i < 4; i++) begin
      host_u.rd_byte(d8);
      `CMP("plain byte", 8'(32'h0000_8003 >> (8 * (3 - i))), d8)
    end
    host_u.pulse(3, 8'h00);
    wb(1'b1, ADR_CTRL, 32'h0000_0100, r);
    chk(ADR_STATUS, 32'h0000_0001, "soft reset");
    chk(ADR_HUM_PRES, {PRES_DEFAULT, HUM_DEFAULT}, "reloaded");
    stop_test();
  end
endmodule : gas_sensor_compensation_measure_cmds_tb

// >>> bench/i2c_host_model.sv
/*
  Host side of the sensor link: frames commands, reads results.
  Assumes link_out is registered on ref_clk and answers within 4 cycles.
*/
`timescale 1ns/1ps
module i2c_host_model
  import gas_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire link_out_t link_out,
  output link_in_t link_in
);
  initial link_in = '0;

  // ****************************************
  // Checksum and link pulses
  // ****************************************
  function automatic logic [7:0] sum8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction : sum8

  // Released data shows the inverse, never a stale byte
  task automatic pulse(input int k, input logic [7:0] b);
    @(posedge ref_clk);
    link_in.begin_frame <= (k == 0);
    link_in.rd_hdr <= (k == 1);
    link_in.rd_req <= (k == 2);
    link_in.stop <= (k == 3);
    link_in.wr_valid <= (k == 4);
    link_in.wr_data <= b;
    @(posedge ref_clk);
    link_in.begin_frame <= 1'b0;
    link_in.rd_hdr <= 1'b0;
    link_in.rd_req <= 1'b0;
    link_in.stop <= 1'b0;
    link_in.wr_valid <= 1'b0;
    link_in.wr_data <= ~b;
  endtask : pulse

  task automatic get_ack(output logic a);
    a = 1'bx;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      if (link_out.ack_valid === 1'b1) begin
        a = link_out.ack;
        break;
      end
    end
  endtask : get_ack

  task automatic rd_byte(output logic [7:0] d);
    d = 8'hxx;
    pulse(2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      if (link_out.rd_valid === 1'b1) begin
        d = link_out.rd_data;
        break;
      end
    end
  endtask : rd_byte

  task automatic put(input logic [7:0] b, output logic a);
    pulse(4, b);
    get_ack(a);
  endtask : put

  // Returns the answer to the last byte; ck: 0 none, 1 good, 2 corrupted
  task automatic send(input logic [15:0] code, input logic [15:0] arg,
                      input int nargs, input int ck, output logic a);
    logic [7:0] s;
    s = sum8(arg) ^ ((ck == 2) ? 8'h5A : 8'h00);
    pulse(0, 8'h00);
    put(code[15:8], a);
    put(code[7:0], a);
    if (nargs != 0) begin
      put(arg[15:8], a);
      put(arg[7:0], a);
    end
    if (ck != 0) begin
      put(s, a);
    end
    pulse(3, 8'h00);
  endtask : send
endmodule : i2c_host_model

// >>> hdl/gas_cmd_core.sv
/*
  Command handler of a thermal-conductivity gas sensor behind an I2C
  target front end, with a classic Wishbone slave for local control.
  Assumes the front end delivers bytes, read headers, read requests and
  stops as one-cycle pulses synchronous to ref_clk.
*/
// Operation
// - Humidity command; default zero percent
// - Compensation inputs held until replaced
// - Argument checksum verified before acting
// - Bad humidity checksum: NACK, keep old
// - Signed temperature command; else internal temperature
// - Bad temperature checksum: NACK, keep old
// - Pressure command; default 1013 millibar
// - Bad pressure checksum: NACK, keep old
// - Read header NACKed until result ready
// - Three words, MSB first, each checksummed
// - Host may end readout any byte
// - Result temperature: written value else internal
// - Recalibration shifts output to reference
// - Recalibration without argument uses zero
// - Recalibration lasts one measurement time
// - Bad recalibration checksum: NACK, use zero
// - Correction valid only for its mode
// - Correction lost on power cycle
// - Checksum disable command; re-enabled on reset
// - No gas selected: NACK measurement read
`timescale 1ns/1ps
module gas_cmd_core
  import gas_cmd_pkg::*;
#(
  parameter int unsigned meas_cycles = MEAS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire link_in_t link_in,
  output link_out_t link_out
);

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic gas_sel;
  logic [3:0] gas_mode;
  logic [15:0] raw_conc;
  logic [15:0] int_temp;
  logic crc_en;
  logic busy;
  logic ready;
  logic temp_written;
  logic ofs_valid;
  logic [3:0] ofs_mode;
  logic [15:0] hum;
  logic [15:0] pres;
  logic [15:0] temp_comp;
  logic [15:0] offset;
  logic [15:0] res_conc;
  logic [15:0] res_temp;
  wire wb_req;
  wire wb_wr;
  wire sel_ctrl;
  wire sel_raw;
  wire soft_pulse;
  wire wake_pulse;
  wire reload;
  wire [31:0] next_rdata;
  wire [31:0] status_word;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master samples ack
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign sel_ctrl = wb_adr_i == ADR_CTRL;
  assign sel_raw = wb_adr_i == ADR_RAW;
  assign soft_pulse = wb_wr & sel_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_SOFT_RST];
  assign wake_pulse = wb_wr & sel_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_WAKE];
  assign reload = soft_pulse | wake_pulse;
  assign status_word = {27'h000_0000, ofs_valid, temp_written, ready, busy, crc_en};
  assign next_rdata =
    (wb_adr_i == ADR_CTRL) ? {24'h00_0000, gas_mode, 3'b000, gas_sel} :
    (wb_adr_i == ADR_RAW) ? {int_temp, raw_conc} :
    (wb_adr_i == ADR_STATUS) ? status_word :
    (wb_adr_i == ADR_HUM_PRES) ? {pres, hum} :
    (wb_adr_i == ADR_TEMP_OFS) ? {offset, temp_comp} :
    (wb_adr_i == ADR_RESULT) ? {res_temp, res_conc} : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gas_sel <= 1'b0;
      gas_mode <= MODE_RESET;
      raw_conc <= 16'h0000;
      int_temp <= 16'h0000;
    end else begin
      if (wb_wr & sel_ctrl & wb_sel_i[0]) begin
        gas_sel <= wb_dat_i[CTRL_GAS_SEL];
        gas_mode <= wb_dat_i[CTRL_MODE_LSB +: 4];
      end
      if (wb_wr & sel_raw & wb_sel_i[0]) raw_conc[7:0] <= wb_dat_i[7:0];
      if (wb_wr & sel_raw & wb_sel_i[1]) raw_conc[15:8] <= wb_dat_i[15:8];
      if (wb_wr & sel_raw & wb_sel_i[2]) int_temp[7:0] <= wb_dat_i[23:16];
      if (wb_wr & sel_raw & wb_sel_i[3]) int_temp[15:8] <= wb_dat_i[31:24];
    end
  end

  // ****************************************
  // Command parser
  // ****************************************
  logic [2:0] idx;
  logic [15:0] cmd;
  logic [15:0] arg;
  wire wv;
  wire [15:0] next_cmd;
  wire [15:0] arg_word;
  wire arg_cmd;
  wire crc_ok;
  wire good;
  wire exec_now;
  wire [15:0] exec_val;
  wire load_hum;
  wire load_temp;
  wire load_pres;
  wire recal_go;
  wire [15:0] recal_val;
  wire meas_go;
  wire crc_off;
  wire start;
  wire byte_nack;
  wire done;

  assign wv = link_in.wr_valid;
  assign next_cmd = {cmd[15:8], link_in.wr_data};
  assign arg_word = {arg[15:8], link_in.wr_data};
  assign arg_cmd = (cmd == CMD_HUM) | (cmd == CMD_TEMP) |
                   (cmd == CMD_PRES) | (cmd == CMD_RECAL);
  assign crc_ok = crc8(arg) == link_in.wr_data;
  // Without checksum the low argument byte completes the command
  assign exec_now = wv & arg_cmd &
                    (((idx == 3'd3) & ~crc_en) | ((idx == 3'd4) & crc_en));
  assign good = ~crc_en | crc_ok;
  assign exec_val = crc_en ? arg : arg_word;
  assign load_hum = exec_now & good & (cmd == CMD_HUM);
  assign load_temp = exec_now & good & (cmd == CMD_TEMP);
  assign load_pres = exec_now & good & (cmd == CMD_PRES);
  // A stop right after the code is a recalibration without argument
  assign recal_go = (cmd == CMD_RECAL) &
                    (exec_now | (link_in.stop & (idx == 3'd2)));
  assign recal_val = (exec_now & good) ? exec_val : RECAL_DEFAULT;
  assign meas_go = wv & (idx == 3'd1) & (next_cmd == CMD_MEAS);
  assign crc_off = wv & (idx == 3'd1) & (next_cmd == CMD_CRC_OFF);
  // Requests while a conversion runs are dropped, not queued
  assign start = (meas_go | recal_go) & ~busy;
  assign byte_nack = wv & (idx == 3'd4) & crc_en & arg_cmd & ~crc_ok;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx <= 3'd0;
      cmd <= 16'h0000;
      arg <= 16'h0000;
    end else if (link_in.begin_frame | link_in.stop) begin
      idx <= 3'd0;
    end else if (wv) begin
      idx <= (idx == 3'd5) ? idx : idx + 3'd1;
      if (idx == 3'd0) cmd[15:8] <= link_in.wr_data;
      if (idx == 3'd1) cmd[7:0] <= link_in.wr_data;
      if (idx == 3'd2) arg[15:8] <= link_in.wr_data;
      if (idx == 3'd3) arg[7:0] <= link_in.wr_data;
    end
  end

  // ****************************************
  // Compensation inputs and checksum mode
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hum <= HUM_DEFAULT;
      pres <= PRES_DEFAULT;
      temp_comp <= 16'h0000;
      temp_written <= 1'b0;
      crc_en <= 1'b1;
    end else if (reload) begin
      hum <= HUM_DEFAULT;
      pres <= PRES_DEFAULT;
      temp_comp <= 16'h0000;
      temp_written <= 1'b0;
      crc_en <= 1'b1;
    end else begin
      if (load_hum) hum <= exec_val;
      if (load_pres) pres <= exec_val;
      if (load_temp) begin
        temp_comp <= exec_val;
        temp_written <= 1'b1;
      end
      if (crc_off) crc_en <= 1'b0;
    end
  end

  // ****************************************
  // Measurement and recalibration
  // ****************************************
  logic recal_pending;
  logic [15:0] recal_ref;
  wire ofs_applies;
  wire [15:0] corrected;

  meas_timer #(
    .cycles(meas_cycles)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(start),
    .abort(reload),
    .busy(busy),
    .done(done)
  );

  assign ofs_applies = ofs_valid & (ofs_mode == gas_mode);
  assign corrected = raw_conc + (ofs_applies ? offset : 16'h0000);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      recal_pending <= 1'b0;
      recal_ref <= 16'h0000;
      offset <= 16'h0000;
      ofs_mode <= MODE_RESET;
      ofs_valid <= 1'b0;
      ready <= 1'b0;
      res_conc <= 16'h0000;
      res_temp <= 16'h0000;
    end else if (reload) begin
      recal_pending <= 1'b0;
      ready <= 1'b0;
      if (soft_pulse) ofs_valid <= 1'b0;
    end else begin
      if (start) begin
        recal_pending <= recal_go;
        recal_ref <= recal_val;
        ready <= 1'b0;
      end else if (done) begin
        recal_pending <= 1'b0;
      end
      // A finishing conversion still lands when the next one starts
      if (done) begin
        if (recal_pending) begin
          offset <= recal_ref - raw_conc;
          ofs_mode <= gas_mode;
          ofs_valid <= 1'b1;
        end else begin
          res_conc <= corrected;
          res_temp <= temp_written ? temp_comp : int_temp;
          ready <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Readout and link answers
  // ****************************************
  logic rd_active;
  logic [1:0] word;
  logic [1:0] part;
  wire hdr_ok;
  wire [15:0] cur_word;
  wire [1:0] last_part;
  wire [7:0] next_byte;

  // Gas must still be selected, so a lost configuration shows as NACK
  assign hdr_ok = ready & ~busy & gas_sel;
  assign cur_word = (word == 2'd0) ? res_conc :
                    (word == 2'd1) ? res_temp : 16'h0000;
  assign last_part = crc_en ? 2'd2 : 2'd1;
  assign next_byte = (word > 2'd2) ? NO_DATA :
                     (part == 2'd0) ? cur_word[15:8] :
                     (part == 2'd1) ? cur_word[7:0] : crc8(cur_word);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_active <= 1'b0;
      word <= 2'd0;
      part <= 2'd0;
      link_out <= '0;
    end else begin
      link_out.ack_valid <= wv | link_in.rd_hdr;
      link_out.ack <= link_in.rd_hdr ? hdr_ok : ~byte_nack;
      link_out.rd_valid <= link_in.rd_req & rd_active;
      if (link_in.rd_req & rd_active) link_out.rd_data <= next_byte;
      if (link_in.stop | link_in.begin_frame | reload) begin
        rd_active <= 1'b0;
      end else if (link_in.rd_hdr) begin
        rd_active <= hdr_ok;
        word <= 2'd0;
        part <= 2'd0;
      end else if (link_in.rd_req & rd_active & (word <= 2'd2)) begin
        part <= (part == last_part) ? 2'd0 : part + 2'd1;
        if (part == last_part) word <= word + 2'd1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_hum_default: assert property (reload |=> hum == HUM_DEFAULT)
    else $error("humidity not reloaded");
  chk_pres_default: assert property (reload |=> pres == PRES_DEFAULT)
    else $error("pressure not reloaded");
  chk_comp_hold: assert property (!load_hum && !reload |=> $stable(hum))
    else $error("humidity changed without a write");
  chk_bad_crc_nack: assert property (byte_nack |=> link_out.ack_valid && !link_out.ack)
    else $error("bad checksum not refused");
  chk_bad_crc_keep: assert property (byte_nack && !reload |=> $stable(pres) && $stable(temp_comp))
    else $error("bad checksum changed a value");
  chk_hdr_not_ready: assert property (link_in.rd_hdr && !ready |=> !link_out.ack)
    else $error("read header acked before result");
  chk_no_gas_nack: assert property (link_in.rd_hdr && !gas_sel |=> !link_out.ack)
    else $error("read acked with no gas selected");
  chk_crc_reenable: assert property (reload |=> crc_en)
    else $error("checksum not re-enabled");
  chk_recal_zero: assert property (start && byte_nack |=> recal_ref == RECAL_DEFAULT)
    else $error("bad recalibration not zero");
  chk_result_temp: assert property (done && !recal_pending && temp_written && !reload
                                    |=> res_temp == $past(temp_comp))
    else $error("result temperature not host value");

  cov_measure_read: cover property (done ##[1:50] link_in.rd_hdr && hdr_ok);
  cov_recal_done: cover property (recal_pending && done);
  cov_bad_crc: cover property (byte_nack);
  cov_crc_off: cover property (crc_off);

endmodule : gas_cmd_core

// >>> hdl/gas_cmd_pkg.sv
/*
  Shared constants, command codes, register map and link carriers of the
  gas sensor command handler. Assumes a 250 MHz core clock.
*/
package gas_cmd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int MEAS_TIME_US = 1000;
  localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [15:0] CMD_CRC_OFF = 16'h3768;
  localparam logic [15:0] CMD_HUM = 16'h3624;
  localparam logic [15:0] CMD_TEMP = 16'h361E;
  localparam logic [15:0] CMD_PRES = 16'h362F;
  localparam logic [15:0] CMD_MEAS = 16'h3639;
  localparam logic [15:0] CMD_RECAL = 16'h3661;

  // ****************************************
  // Defaults and checksum
  // ****************************************
  localparam logic [15:0] HUM_DEFAULT = 16'h0000;
  localparam logic [15:0] PRES_DEFAULT = 16'h03F5;
  localparam logic [15:0] RECAL_DEFAULT = 16'h0000;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] NO_DATA = 8'hFF;

  // ****************************************
  // Register map (byte addresses) and fields
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_RAW = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_HUM_PRES = 8'h0C;
  localparam logic [7:0] ADR_TEMP_OFS = 8'h10;
  localparam logic [7:0] ADR_RESULT = 8'h14;
  localparam int CTRL_GAS_SEL = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SOFT_RST = 8;
  localparam int CTRL_WAKE = 9;
  localparam logic [3:0] MODE_RESET = 4'h0;

  typedef struct packed {
    logic begin_frame;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_hdr;
    logic rd_req;
    logic stop;
  } link_in_t;

  typedef struct packed {
    logic ack_valid;
    logic ack;
    logic rd_valid;
    logic [7:0] rd_data;
  } link_out_t;

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

endpackage : gas_cmd_pkg

// >>> hdl/meas_timer.sv
/*
  Measurement duration timer. Assumes start is a one-cycle pulse and is
  only raised while not busy.
*/
`timescale 1ns/1ps
module meas_timer
  import gas_cmd_pkg::*;
#(
  parameter int unsigned cycles = MEAS_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  logic [31:0] count;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0000_0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        count <= cycles - 32'd1;
      end else if (busy) begin
        if (count == 32'h0000_0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 32'd1;
        end
      end
    end
  end

endmodule : meas_timer
